// ### trunk_bridge_pkg.sv
// constants shared by the trunk timeslot drop and bridge logic
// assumes one 100 MHz core clock; trunk clock and frame sync arrive on pins
package trunk_bridge_pkg;
  localparam int NPORTS = 8;
  localparam int NPAIRS = 4;
  localparam int NLANES = 9;
  localparam int BUS_LANE = 8;
  localparam int NSLOTS = 32;
  localparam logic [4:0] E1_SYNC_SLOT = 5'h00;
  localparam logic [4:0] T1_CHANNELS = 5'h18;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] T1_FRAME_LAST = 8'hC0;
  localparam logic [7:0] E1_FRAME_LAST = 8'hFF;
  localparam logic [31:0] T1_VALID_MASK = 32'h00FFFFFF;
  localparam logic [31:0] E1_VALID_MASK = 32'hFFFFFFFE;
  localparam logic [6:0] MAX_LINKS = 7'h40;
  localparam logic [6:0] DEFAULT_LINKS = 7'h10;
  localparam logic [7:0] IDLE_DEFAULT = 8'hFF;
  // register map, word addresses on the plain register port
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CAP = 8'h01;
  localparam logic [7:0] A_IDLE = 8'h02;
  localparam logic [7:0] A_CHSEL = 8'h03;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_ALARM = 8'h05;
  localparam logic [4:0] SEL_PAGE = 5'h02;
  localparam logic [4:0] ERR_PAGE = 5'h03;
  // field positions
  localparam int CTRL_E1_BIT = 0;
  localparam int CTRL_CHAN_BIT = 1;
  localparam int CTRL_BRIDGE_LSB = 2;
  localparam int CTRL_CHCARD_BIT = 6;
  localparam int CTRL_HST_BIT = 7;
  localparam int CHSEL_B_LSB = 8;
  localparam int ST_REFUSED_BIT = 8;
endpackage

// ### trunk_timing_if.sv
// bit and slot timing handed from the trunk timer to the bridge
// assumes both ends on the same core clock
`timescale 1ns/1ps
interface trunk_timing_if;
  logic e1;
  logic rx_stb;
  logic tx_stb;
  logic [4:0] slot;
  logic [2:0] bit_idx;
  logic fbit;
  modport timer (input e1, output rx_stb, output tx_stb, output slot, output bit_idx, output fbit);
  modport user (output e1, input rx_stb, input tx_stb, input slot, input bit_idx, input fbit);
endinterface

// ### trunk_timing.sv
// trunk bit timer: samples the trunk clock and frame sync, tracks frame position
// assumes trunk clock far slower than the core clock (a few core cycles per half period)
`timescale 1ns/1ps
module trunk_timing
  import trunk_bridge_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic rst, // synchronous reset, high
  input wire logic trunk_clk, // trunk bit clock pin
  input wire logic trunk_fs, // frame sync pin, high on bit 0
  trunk_timing_if.timer t // timing toward the bridge
);
  typedef struct packed {
    logic [2:0] ck;
    logic [1:0] fs;
    logic [7:0] pos;
  } tstate_t;
  tstate_t st;
  tstate_t next_st;

  always_comb
  begin
    logic rise;
    logic fall;
    logic [7:0] last;
    logic [7:0] pos_tx;
    logic [7:0] pos_rx;
    logic [7:0] cur;
    logic [7:0] tmp;
    next_st = st;
    next_st.ck = {st.ck[1:0], trunk_clk};
    next_st.fs = {st.fs[0], trunk_fs};
    rise = st.ck[1] & ~st.ck[2];
    fall = ~st.ck[1] & st.ck[2];
    last = t.e1 ? E1_FRAME_LAST : T1_FRAME_LAST;
    pos_tx = (st.pos == last) ? '0 : st.pos + 8'h01;
    // frame sync realigns on the sampling edge, so a slip costs at most one frame
    pos_rx = st.fs[1] ? '0 : st.pos;
    if (rise)
      next_st.pos = pos_rx;
    if (fall)
      next_st.pos = pos_tx;
    cur = fall ? pos_tx : pos_rx;
    tmp = cur - 8'h01;
    if (t.e1)
    begin
      t.slot = cur[7:3];
      t.bit_idx = cur[2:0];
      t.fbit = 1'b0;
    end
    else
    begin
      t.slot = tmp[7:3];
      t.bit_idx = tmp[2:0];
      t.fbit = (cur == '0);
    end
    t.rx_stb = rise;
    t.tx_stb = fall;
    if (rst)
      next_st = '0;
  end

  always_ff @(posedge clock)
  begin
    st <= next_st;
  end
endmodule // trunk_timing

// ### trunk_drop_bridge.sv
// eight-port trunk timeslot drop, insert and odd/even channel bridge
// assumes all ports share one trunk clock and frame sync; framer alarms on core clock
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
module trunk_drop_bridge
  import trunk_bridge_pkg::*;
(
  input wire logic clock, // core clock, 100 MHz
  input wire logic rst, // synchronous reset, high
  input wire logic trunk_clk, // shared trunk bit clock pin
  input wire logic trunk_fs, // shared frame sync pin
  input wire logic [3:0] rx_a, // receive data ports 1-4, interface A
  input wire logic [3:0] rx_b, // receive data ports 5-8, interface B
  input wire logic bus_rx, // shared backplane trunk bus receive
  output logic [3:0] tx_a, // transmit data ports 1-4
  output logic [3:0] tx_b, // transmit data ports 5-8
  input wire logic [7:0] reg_addr, // register word address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, cycle after strobe
  output logic [8:0] drop_valid, // dropped octet pulse per lane, lane 8 is bus
  output logic [4:0] drop_slot, // timeslot of dropped octets
  output logic [71:0] drop_data, // dropped octets, lane n at 8n
  output logic ins_take, // signaling octets sampled this cycle
  output logic [4:0] ins_slot, // timeslot being loaded
  input wire logic [63:0] ins_data, // signaling octet per port for ins_slot
  input wire logic [7:0] sync_alarm, // per-port loss of sync from framer
  input wire logic [7:0] frame_alarm, // per-port framing alarm from framer
  input wire logic [7:0] remote_alarm, // per-port remote alarm from framer
  input wire logic [7:0] line_err, // per-port line error pulse from framer
  output logic hs_rate_e1, // high-speed master clock rate is E1
  output logic hs_timing_en // high-speed master timing requested
);
  typedef struct packed {
    logic e1;
    logic chan;
    logic [3:0] bridge;
    logic chcard;
    logic hst;
    logic [6:0] cap;
    logic [7:0] idle;
    logic [4:0] ch_a;
    logic [4:0] ch_b;
    logic refused;
    logic [7:0][31:0] sel;
    logic [31:0] rdata;
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0][7:0] rx_sh;
    logic [7:0][31:0][7:0] rx_buf;
    logic [7:0][7:0] tx_sh;
    logic [7:0] tx_out;
    logic [8:0] dvalid;
    logic [8:0][7:0] ddata;
    logic [4:0] dslot;
    logic [7:0][7:0] err;
  } state_t;
  state_t st;
  state_t next_st;

  trunk_timing_if t ();

  trunk_timing u_timing (
    .clock(clock),
    .rst(rst),
    .trunk_clk(trunk_clk),
    .trunk_fs(trunk_fs),
    .t(t.timer)
  );

  function automatic logic [5:0] pop32(input logic [31:0] v);
    logic [5:0] n;
    n = '0;
    for (int i = 0; i < NSLOTS; i++)
      n = n + {5'h00, v[i]};
    return n;
  endfunction

  logic [31:0] valid_mask;
  logic [3:0] bact;
  logic [7:0] slave_mask;
  logic [7:0][31:0] eff;
  logic [8:0] count;
  logic load;

  assign t.e1 = st.e1;
  assign valid_mask = st.e1 ? E1_VALID_MASK : T1_VALID_MASK;
  assign bact = st.chan ? st.bridge : '0;

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++)
    begin : g_eff
      // a bridged slave's selections are hidden, not erased
      assign slave_mask[g] = (g % 2 == 1) ? bact[g / 2] : 1'b0;
      assign eff[g] = st.sel[g] & valid_mask & {NSLOTS{~slave_mask[g]}};
    end
  endgenerate

  always_comb
  begin
    logic [8:0] acc;
    acc = '0;
    for (int p = 0; p < NPORTS; p++)
      acc = acc + {3'h0, pop32(eff[p])};
    count = acc;
  end

  assign load = t.tx_stb && (t.bit_idx == '0) && !t.fbit;

  always_comb
  begin
    logic [31:0] newm;
    logic [8:0] newcount;
    logic [2:0] idx;
    logic [7:0] oct;
    logic [7:0] ins;
    logic [6:0] capw;
    newm = '0;
    newcount = '0;
    idx = reg_addr[2:0];
    oct = '0;
    ins = '0;
    capw = '0;
    next_st = st;
    next_st.s1 = {bus_rx, rx_b, rx_a};
    next_st.s2 = st.s1;
    next_st.dvalid = '0;
    next_st.rdata = '0;

    // receive: shift in, store for bridging, drop selected slots
    if (t.rx_stb && !t.fbit)
    begin
      for (int l = 0; l < NLANES; l++)
      begin
        oct = {st.rx_sh[l][6:0], st.s2[l]};
        next_st.rx_sh[l] = oct;
        if (t.bit_idx == LAST_BIT)
        begin
          next_st.dslot = t.slot;
          next_st.ddata[l] = oct;
          if (l == BUS_LANE)
            next_st.dvalid[l] = st.chcard && (t.slot == st.ch_a || t.slot == st.ch_b);
          else
          begin
            // low three bits keep the index in range for the unrolled bus lane
            next_st.rx_buf[l[2:0]][t.slot] = oct;
            next_st.dvalid[l] = !st.chcard && eff[l[2:0]][t.slot];
          end
        end
      end
    end

    // transmit: load one octet per port at each slot start, shift otherwise
    if (t.tx_stb && !t.fbit)
    begin
      for (int p = 0; p < NPORTS; p++)
      begin
        if (t.bit_idx == '0)
        begin
          ins = ins_data[8 * p +: 8];
          if (bact[p / 2] && (p % 2 == 0))
            oct = eff[p][t.slot] ? ins : st.rx_buf[p ^ 1][t.slot];
          else if (bact[p / 2])
            oct = eff[p ^ 1][t.slot] ? st.idle : st.rx_buf[p ^ 1][t.slot];
          else
            oct = eff[p][t.slot] ? ins : st.idle;
          next_st.tx_out[p] = oct[7];
          next_st.tx_sh[p] = {oct[6:0], 1'b0};
        end
        else
        begin
          next_st.tx_out[p] = st.tx_sh[p][7];
          next_st.tx_sh[p] = {st.tx_sh[p][6:0], 1'b0};
        end
      end
    end

    // statistics are not kept for a bridged slave
    for (int p = 0; p < NPORTS; p++)
      if (line_err[p] && !slave_mask[p])
        next_st.err[p] = st.err[p] + 8'h01;

    if (reg_wr)
    begin
      if (reg_addr == A_CTRL)
      begin
        next_st.e1 = reg_wdata[CTRL_E1_BIT];
        next_st.chan = reg_wdata[CTRL_CHAN_BIT];
        next_st.bridge = reg_wdata[CTRL_BRIDGE_LSB +: NPAIRS];
        next_st.chcard = reg_wdata[CTRL_CHCARD_BIT];
        next_st.hst = reg_wdata[CTRL_HST_BIT];
      end
      else if (reg_addr == A_CAP)
      begin
        // the whole word is compared so that large values clamp instead of wrapping
        capw = (reg_wdata > {25'h0, MAX_LINKS}) ? MAX_LINKS : reg_wdata[6:0];
        // lowering the cap under the present total would strand live links
        if ({2'h0, capw} < count)
          next_st.refused = 1'b1;
        else
          next_st.cap = capw;
      end
      else if (reg_addr == A_IDLE)
        next_st.idle = reg_wdata[7:0];
      else if (reg_addr == A_CHSEL)
      begin
        next_st.ch_a = reg_wdata[4:0];
        next_st.ch_b = reg_wdata[CHSEL_B_LSB +: 5];
      end
      else if (reg_addr[7:3] == SEL_PAGE)
      begin
        newm = reg_wdata & valid_mask;
        newcount = count - {3'h0, pop32(eff[idx])} + {3'h0, pop32(newm)};
        if ((slave_mask[idx] && newm != '0) || newcount > {2'h0, st.cap})
          next_st.refused = 1'b1;
        else
          next_st.sel[idx] = newm;
      end
      else if (reg_addr == A_STATUS && reg_wdata[ST_REFUSED_BIT])
        next_st.refused = 1'b0;
    end

    if (reg_rd)
    begin
      if (reg_addr == A_CTRL)
      begin
        next_st.rdata[CTRL_E1_BIT] = st.e1;
        next_st.rdata[CTRL_CHAN_BIT] = st.chan;
        next_st.rdata[CTRL_BRIDGE_LSB +: NPAIRS] = st.bridge;
        next_st.rdata[CTRL_CHCARD_BIT] = st.chcard;
        next_st.rdata[CTRL_HST_BIT] = st.hst;
      end
      else if (reg_addr == A_CAP)
        next_st.rdata[6:0] = st.cap;
      else if (reg_addr == A_IDLE)
        next_st.rdata[7:0] = st.idle;
      else if (reg_addr == A_CHSEL)
      begin
        next_st.rdata[4:0] = st.ch_a;
        next_st.rdata[CHSEL_B_LSB +: 5] = st.ch_b;
      end
      else if (reg_addr == A_STATUS)
      begin
        next_st.rdata[8:0] = count;
        next_st.rdata[ST_REFUSED_BIT] = st.refused;
      end
      else if (reg_addr == A_ALARM)
      begin
        next_st.rdata[7:0] = sync_alarm | frame_alarm;
        next_st.rdata[15:8] = remote_alarm & ~slave_mask;
      end
      else if (reg_addr[7:3] == SEL_PAGE)
        next_st.rdata = st.sel[idx];
      else if (reg_addr[7:3] == ERR_PAGE)
        next_st.rdata[7:0] = st.err[idx];
    end

    if (rst)
    begin
      next_st = '0;
      next_st.cap = DEFAULT_LINKS;
      next_st.idle = IDLE_DEFAULT;
    end
  end

  always_ff @(posedge clock)
  begin
    st <= next_st;
  end

  assign tx_a = st.tx_out[3:0];
  assign tx_b = st.tx_out[7:4];
  assign reg_rdata = st.rdata;
  assign drop_valid = st.dvalid;
  assign drop_slot = st.dslot;
  assign drop_data = st.ddata;
  assign ins_take = load;
  assign ins_slot = t.slot;
  // one clock rate for every port; pairs are timed together by the shared trunk clock
  assign hs_rate_e1 = st.e1;
  assign hs_timing_en = st.hst;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  logic [7:0] pass_msb;
  logic [7:0] ins_msb;
  logic [7:0] slave_q;
  always_ff @(posedge clock)
  begin
    slave_q <= slave_mask;
  end

  generate
    for (g = 0; g < NPAIRS; g++)
    begin : g_chk
      assign pass_msb[2 * g] = st.rx_buf[2 * g + 1][t.slot][7];
      assign pass_msb[2 * g + 1] = st.rx_buf[2 * g][t.slot][7];
      assign ins_msb[2 * g] = ins_data[16 * g + 7];
      assign ins_msb[2 * g + 1] = ins_data[16 * g + 15];

      sequence s_drop_load;
        load && bact[g] && eff[2 * g][t.slot];
      endsequence
      sequence s_pass_load;
        load && bact[g] && !eff[2 * g][t.slot];
      endsequence

      chk_slave_idle_fill: assert property (s_drop_load |=> st.tx_out[2 * g + 1] == $past(st.idle[7]))
        else $error("slave slot dropped from master not idle filled");
      chk_slave_pass_data: assert property (s_pass_load |=> st.tx_out[2 * g + 1] == $past(pass_msb[2 * g + 1]))
        else $error("master data not passed to slave in same slot");
      chk_master_pass_data: assert property (s_pass_load |=> st.tx_out[2 * g] == $past(pass_msb[2 * g]))
        else $error("slave data overwritten on master port");
      chk_master_merge_sig: assert property (s_drop_load |=> st.tx_out[2 * g] == $past(ins_msb[2 * g]))
        else $error("signaling octet not merged on master port");
      chk_slave_no_stats: assert property (bact[g] ##1 bact[g] |-> $stable(st.err[2 * g + 1]))
        else $error("statistics counted on bridged slave");
    end
  endgenerate

  chk_e1_sync_slot: assert property ($past(st.e1) && |drop_valid[7:0] |-> drop_slot != E1_SYNC_SLOT)
    else $error("E1 sync slot dropped as a link");
  chk_t1_chan_range: assert property (!$past(st.e1) && |drop_valid[7:0] |-> drop_slot < T1_CHANNELS)
    else $error("T1 drop outside 24 channels");
  chk_link_cap_total: assert property (count <= {2'h0, st.cap} && st.cap <= MAX_LINKS)
    else $error("selected links exceed cap");
  chk_bridge_chan_mode: assert property (!st.chan |-> slave_mask == '0 && bact == '0)
    else $error("bridging active outside channelized mode");
  chk_slave_no_drop: assert property (|drop_valid[7:0] |-> (drop_valid[7:0] & slave_q) == '0)
    else $error("link dropped on bridged slave");
  chk_bus_two_chan: assert property (drop_valid[BUS_LANE] |-> drop_slot == $past(st.ch_a) || drop_slot == $past(st.ch_b))
    else $error("bus drop outside chosen channels");
endmodule // trunk_drop_bridge

// ### trunk_far_end.sv
// far-end trunk elements: E1 frames on every lane, and capture of returned octets
// assumes the card runs E1; bits change on the falling link edge, sampled on the rising one
`timescale 1ns/1ps
module trunk_far_end
(
  output logic trunk_clk, // free-running link clock, 125 ns
  output logic trunk_fs, // high during bit 0 of each frame
  output logic [3:0] rx_a, // toward ports 1-4
  output logic [3:0] rx_b, // toward ports 5-8
  output logic bus_rx, // shared backplane bus lane
  input wire logic [3:0] tx_a, // from ports 1-4
  input wire logic [3:0] tx_b // from ports 5-8
);
  logic [7:0] pos = 8'hFF;
  logic [7:0] o;
  logic [8:0] b = 9'h000;
  logic [7:0] tx;
  logic [7:0] sh [8];
  logic [7:0] got [8][32]; // last octet seen per port and slot

  assign tx = {tx_b, tx_a};
  assign rx_a = b[3:0];
  assign rx_b = b[7:4];
  assign bus_rx = b[8];
  assign trunk_fs = (pos == 8'h00);

  // one clock times every port, so bridged pairs stay in step
  initial
  begin
    trunk_clk = 1'h0;
    forever #62.5 trunk_clk = ~trunk_clk;
  end

  // each lane carries octet {lane mod 8, slot} in every slot, so no slot ever goes silent
  always @(negedge trunk_clk)
  begin
    pos = pos + 8'h01;
    for (int l = 0; l < 9; l++)
    begin
      o = {l[2:0], pos[7:3]};
      b[l] = o[3'h7 - pos[2:0]];
    end
  end

  always @(posedge trunk_clk)
  begin
    for (int p = 0; p < 8; p++)
    begin
      sh[p] = {sh[p][6:0], tx[p]};
      if (pos[2:0] == 3'h7)
        got[p][pos[7:3]] = sh[p];
    end
  end
endmodule // trunk_far_end

// ### trunk_drop_bridge_test.sv
// bench for the trunk drop and bridge block, driven through its register port
// assumes the far-end model supplies E1 frames on every lane
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s: expected %0h, seen %0h", n, e, g); end end
module trunk_drop_bridge_test
  import trunk_bridge_pkg::*;
;
  localparam logic [7:0] IDL = 8'h3C;
  logic clock, rst, trunk_clk, trunk_fs, bus_rx, reg_wr, reg_rd, ins_take, hs_rate_e1, hs_timing_en;
  logic [3:0] rx_a, rx_b, tx_a, tx_b;
  logic [7:0] reg_addr, sync_alarm, frame_alarm, remote_alarm, line_err;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0] drop_valid;
  logic [4:0] drop_slot, ins_slot;
  logic [71:0] drop_data;
  logic [63:0] ins_data;
  int error_cnt, check_count, cycles, tdrops;

  trunk_drop_bridge dut
  (
    .clock, .rst, .trunk_clk, .trunk_fs, .rx_a, .rx_b, .bus_rx, .tx_a, .tx_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .drop_valid, .drop_slot, .drop_data,
    .ins_take, .ins_slot, .ins_data, .sync_alarm, .frame_alarm, .remote_alarm, .line_err,
    .hs_rate_e1, .hs_timing_en
  );

  trunk_far_end far
  (
    .trunk_clk, .trunk_fs, .rx_a, .rx_b, .bus_rx, .tx_a, .tx_b
  );

  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end

  task automatic close_out();
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // about eleven frames of traffic are needed; this leaves ample margin
  always @(posedge clock)
  begin
    cycles++;
    if (drop_valid[7:0] !== 8'h00)
      tdrops++;
    if (cycles == 70000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // tasks start just after a rising edge; a gap cycle keeps strobes from being set twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clock);
    reg_wr <= 1'h0;
    @(posedge clock);
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 `CHK(n, e, reg_rdata)
    @(posedge clock);
    #1 `CHK("rdata release", 32'h0, reg_rdata)
    @(posedge clock);
  endtask

  task automatic wait_drop(input int l, input logic [4:0] s, input logic [7:0] o);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (!(drop_valid[l] === 1'h1 && drop_slot === s) && n < 8000);
    `CHK("drop seen", 1'h1, drop_valid[l])
    `CHK("drop slot", s, drop_slot)
    `CHK("drop octet", o, drop_data[8 * l +: 8])
    @(posedge clock);
  endtask

  // waits for the load of slot s, then looks at the first bit sent on port 1
  task automatic wait_take(input logic [4:0] s, input logic e);
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      #1 n++;
    end
    while (!(ins_take === 1'h1 && ins_slot === s) && n < 8000);
    `CHK("ins take", 1'h1, ins_take)
    `CHK("ins slot", s, ins_slot)
    @(posedge clock);
    #1 `CHK("tx first bit", e, tx_a[0])
  endtask

  task automatic frames(input int k);
    repeat (k) @(posedge trunk_fs);
    @(posedge clock);
  endtask

  task automatic t_reset();
    rchk("ctrl", A_CTRL, 32'h0);
    rchk("cap", A_CAP, 32'h10);
    rchk("idle", A_IDLE, 32'hFF);
    rchk("unmapped", 8'h07, 32'h0);
    `CHK("hs rate", 1'h0, hs_rate_e1)
    `CHK("hs timing", 1'h0, hs_timing_en)
  endtask

  task automatic t_limits();
    wr(A_CAP, 32'h64);
    rchk("cap clamp", A_CAP, 32'h40);
    wr(8'h10, 32'hFFFFFFFF);
    rchk("t1 mask", 8'h10, 32'h00FFFFFF);
    wr(8'h11, 32'hFFFFFFFF);
    rchk("count", A_STATUS, 32'h30);
    tdrops = 0;
    frames(1);
    `CHK("t1 drops", 1'h1, tdrops != 0)
    wr(8'h12, 32'hFFFFFFFF);
    rchk("over cap", 8'h12, 32'h0);
    rchk("refused", A_STATUS, 32'h130);
    wr(A_STATUS, 32'h100);
    rchk("cleared", A_STATUS, 32'h30);
    wr(8'h10, 32'h0);
    wr(8'h11, 32'h0);
  endtask

  task automatic t_e1_drop();
    wr(A_CTRL, 32'h81);
    `CHK("hs rate", 1'h1, hs_rate_e1)
    `CHK("hs timing", 1'h1, hs_timing_en)
    wr(8'h10, 32'hFFFFFFFF);
    rchk("e1 mask", 8'h10, 32'hFFFFFFFE);
    rchk("e1 count", A_STATUS, 32'h1F);
    wr(8'h10, 32'h8);
    wr(8'h15, 32'h200);
    wr(A_IDLE, {24'h0, IDL});
    wait_drop(0, 5'h03, 8'h03);
    wait_drop(5, 5'h09, 8'hA9);
    wait_take(5'h03, 1'h1);
    frames(2);
    `CHK("insert", 8'hC0, far.got[0][3])
    `CHK("idle fill", IDL, far.got[0][4])
    `CHK("port 6 insert", 8'hC5, far.got[5][9])
  endtask

  task automatic t_bridge();
    wr(A_CTRL, 32'h85);
    frames(3);
    `CHK("no bridge", IDL, far.got[1][5])
    wr(A_CTRL, 32'h8F);
    frames(3);
    `CHK("to slave", 8'h05, far.got[1][5])
    `CHK("same slot", 8'h09, far.got[1][9])
    `CHK("to master", 8'h25, far.got[0][5])
    `CHK("merged", 8'hC0, far.got[0][3])
    `CHK("dropped idle", IDL, far.got[1][3])
    `CHK("pair 3 4", 8'h45, far.got[3][5])
    `CHK("pair 5 6 off", IDL, far.got[5][5])
  endtask

  // deliberately provisions a link on a bridged slave port to see it refused
  task automatic t_slave();
    wr(8'h11, 32'h10);
    rchk("slave select", 8'h11, 32'h0);
    rchk("slave refused", A_STATUS, 32'h102);
    wr(A_STATUS, 32'h100);
    sync_alarm <= 8'h02;
    frame_alarm <= 8'h04;
    remote_alarm <= 8'h03;
    line_err <= 8'h03;
    @(posedge clock);
    line_err <= 8'h00;
    @(posedge clock);
    rchk("alarms", A_ALARM, 32'h0106);
    rchk("master errors", 8'h18, 32'h1);
    rchk("slave errors", 8'h19, 32'h0);
  endtask

  task automatic t_chan_card();
    wr(A_CTRL, 32'h41);
    wr(A_CHSEL, 32'h1104);
    tdrops = 0;
    wait_drop(8, 5'h04, 8'h04);
    wait_drop(8, 5'h11, 8'h11);
    `CHK("trunk drops", 0, tdrops)
  endtask

  initial
  begin
    rst = 1'h1;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ins_data = 64'hC7C6C5C4C3C2C1C0;
    sync_alarm = 8'h00;
    frame_alarm = 8'h00;
    remote_alarm = 8'h00;
    line_err = 8'h00;
    repeat (2) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    t_reset();
    t_limits();
    t_e1_drop();
    t_bridge();
    t_slave();
    t_chan_card();
    close_out();
  end
endmodule // trunk_drop_bridge_test
